// ===== rtl/egm_adapter.sv
// external gmii adapter: tx resample + elastic buffer, registered rx
`timescale 1ns/1ps
module egm_adapter
    import egm_pkg::*;
#(
    parameter int unsigned DATA_W = EGM_DATA_W,
    parameter int unsigned AW     = EGM_FIFO_AW
) (
    input  wire logic              sys_clk_i,      // core clock
    input  wire logic              reset_i,        // sync reset, high
    input  wire logic              ce_i,           // clock enable
    input  wire logic              tx_clk_i,       // partner tx clock pin
    input  wire logic [DATA_W-1:0] tx_data_i,      // partner tx data
    input  wire logic              tx_en_i,        // partner tx enable
    input  wire logic              tx_er_i,        // partner tx error
    output logic      [DATA_W-1:0] core_tx_data_o, // tx data to core
    output logic                   core_tx_en_o,   // tx enable to core
    output logic                   core_tx_er_o,   // tx error to core
    input  wire logic [DATA_W-1:0] core_rx_data_i, // rx data from core
    input  wire logic              core_rx_dv_i,   // rx valid from core
    input  wire logic              core_rx_er_i,   // rx error from core
    output logic      [DATA_W-1:0] rx_data_o,      // rx data pad
    output logic                   rx_dv_o,        // rx valid pad
    output logic                   rx_er_o,        // rx error pad
    output logic                   rx_clk_o        // forwarded rx clock
);
    localparam int unsigned W = DATA_W + 2;
    localparam int unsigned DEPTH = 1 << AW;

    ////////////////////////////////////////////////////////////////////
    // pad capture: sync tx clock and the tx bus in the core domain
    logic [W-1:0] pad_bus_s;
    logic         tclk_s;
    egm_sync2 #(.WIDTH(W)) u_bus_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .async_i   ({tx_er_i, tx_en_i, tx_data_i}),
        .sync_o    (pad_bus_s)
    );
    egm_sync2 #(.WIDTH(1)) u_clk_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .async_i   (tx_clk_i),
        .sync_o    (tclk_s)
    );

    ////////////////////////////////////////////////////////////////////
    // edge find and immediate resample on the partner clock edge
    logic         tclk_q, tclk_d;
    logic [W-1:0] res_q, res_d;     // resampled word
    logic         res_v_q, res_v_d; // one-cycle strobe
    logic         edge_w;

    assign edge_w = tclk_s & ~tclk_q;

    // bus is sampled on each partner rising edge
    always_comb begin
        tclk_d  = tclk_q;
        res_d   = res_q;
        res_v_d = 1'b0;
        if (ce_i) begin
            tclk_d = tclk_s;
            if (edge_w) begin
                res_d   = pad_bus_s;  // third register stage
                res_v_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            tclk_q  <= 1'b0;
            res_q   <= '0;
            res_v_q <= 1'b0;
        end else begin
            tclk_q  <= tclk_d;
            res_q   <= res_d;
            res_v_q <= res_v_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // elastic buffer storage and pointers
    logic [W-1:0]  mem_q [DEPTH];
    logic [AW:0]   wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   fill_w;
    logic          wr_en_w, rd_en_w, drop_w;
    egm_state_t    st_q, st_d;
    logic [W-1:0]  head_w;
    logic [W-1:0]  out_q, out_d;

    assign fill_w = wr_q - rd_q;
    assign head_w = mem_q[rd_q[AW-1:0]];
    // idle words may be discarded when the buffer runs high
    assign drop_w = res_v_q & ~res_q[DATA_W] & (st_q != EGM_ST_DATA)
                  & (fill_w > (AW+1)'(EGM_HIGH_FILL));
    assign wr_en_w = ce_i & res_v_q & ~drop_w
                   & (fill_w != (AW+1)'(DEPTH));

    // write side: store each resampled word that is not dropped and finds room
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_w) begin
            mem_q[wr_q[AW-1:0]] <= res_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read side: core clock drains at most one word a cycle once centred
    always_comb begin
        st_d    = st_q;
        rd_en_w = 1'b0;
        out_d   = out_q;
        if (ce_i) begin
            unique case (st_q)
                EGM_ST_FILL: begin
                    out_d = {2'b00, EGM_IDLE_DATA};
                    if (fill_w >= (AW+1)'(EGM_HALF_FILL)) begin
                        st_d = EGM_ST_IDLE;
                    end
                end
                EGM_ST_IDLE: begin
                    // low fill: repeat idle instead of reading
                    if (fill_w < (AW+1)'(EGM_LOW_FILL)) begin
                        out_d = {2'b00, EGM_IDLE_DATA};
                    end else begin
                        rd_en_w = 1'b1;
                        out_d   = head_w;
                        if (head_w[DATA_W]) begin
                            st_d = EGM_ST_DATA;
                        end
                    end
                end
                EGM_ST_DATA: begin
                    if (fill_w != '0) begin // frame bytes never skipped
                        rd_en_w = 1'b1;
                        out_d   = head_w;
                        if (!head_w[DATA_W]) begin
                            st_d = EGM_ST_IDLE;
                        end
                    end else begin
                        // underrun inside a frame: mark the byte errored
                        // so the core discards the frame, then refill
                        out_d = {2'b11, EGM_IDLE_DATA};
                        st_d  = EGM_ST_FILL;
                    end
                end
                default: st_d = EGM_ST_FILL;
            endcase
        end
    end

    always_comb begin
        wr_d = wr_en_w ? wr_q + 1'b1 : wr_q;
        rd_d = rd_en_w ? rd_q + 1'b1 : rd_q;
    end

    // core side outputs on the core clock
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            st_q  <= EGM_ST_FILL;
            out_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            st_q  <= st_d;
            out_q <= out_d;
        end
    end

    assign core_tx_data_o = out_q[DATA_W-1:0];
    assign core_tx_en_o   = out_q[DATA_W];
    assign core_tx_er_o   = out_q[DATA_W+1];

    ////////////////////////////////////////////////////////////////////
    // receive path: pad registers, single core-clock domain
    logic [DATA_W-1:0] rxd_q, rxd_d;
    logic              rxv_q, rxv_d, rxe_q, rxe_d;
    logic              rck_q, rck_d;

    always_comb begin
        rxd_d = ce_i ? core_rx_data_i : rxd_q; // output flops
        rxv_d = ce_i ? core_rx_dv_i   : rxv_q;
        rxe_d = ce_i ? core_rx_er_i   : rxe_q;
        // a ddr pair here would drive 0 then 1; at one rate per core
        // cycle the flop toggles instead, giving a clock at half the core rate
        rck_d = ce_i ? ~rck_q : rck_q;       // inverted phase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rxd_q <= '0;
            rxv_q <= 1'b0;
            rxe_q <= 1'b0;
            rck_q <= EGM_RXCLK_RESET;
        end else begin
            rxd_q <= rxd_d;
            rxv_q <= rxv_d;
            rxe_q <= rxe_d;
            rck_q <= rck_d;
        end
    end

    assign rx_data_o = rxd_q;
    assign rx_dv_o   = rxv_q;
    assign rx_er_o   = rxe_q;
    assign rx_clk_o  = rck_q;
endmodule // egm_adapter

// ===== shared/egm_pkg.sv
// constants shared by the external gmii adapter files
package egm_pkg;
    localparam int unsigned EGM_DATA_W      = 8;
    localparam int unsigned EGM_FIFO_AW     = 4;   // log2 of buffer depth
    localparam int unsigned EGM_HALF_FILL   = 8;   // centre occupancy
    localparam int unsigned EGM_LOW_FILL    = 4;   // below: stretch idle
    localparam int unsigned EGM_HIGH_FILL   = 12;  // above: shrink idle
    localparam logic [7:0]  EGM_IDLE_DATA   = 8'h00;
    localparam logic        EGM_RXCLK_RESET = 1'b1; // rx clock starts high, then toggles at half the core rate
    typedef enum logic [1:0] {
        EGM_ST_FILL = 2'b00,  // waiting for half fill
        EGM_ST_IDLE = 2'b01,  // between frames
        EGM_ST_DATA = 2'b10   // inside a frame
    } egm_state_t;
endpackage

// ===== rtl/egm_sync2.sv
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module egm_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk_i,  // sampling clock
    input  wire logic             reset_i,    // sync reset, high
    input  wire logic             ce_i,       // clock enable
    input  wire logic [WIDTH-1:0] async_i,    // foreign-domain level
    output logic      [WIDTH-1:0] sync_o      // resynchronised level
);
    logic [WIDTH-1:0] meta_q, meta_d;
    logic [WIDTH-1:0] sync_q, sync_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = ce_i ? async_i : meta_q;
        sync_d = ce_i ? meta_q  : sync_q;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule // egm_sync2

// ===== verif/egm_adapter_props.sv
// port checker for the external gmii adapter
`timescale 1ns/1ps
module egm_adapter_props #(
    parameter int unsigned DATA_W = 8
) (
    input wire logic              sys_clk_i,      // core clock
    input wire logic              reset_i,        // sync reset, high
    input wire logic              ce_i,           // clock enable
    input wire logic              tx_en_i,        // partner tx enable pin
    input wire logic [DATA_W-1:0] core_tx_data_o, // tx data to core
    input wire logic              core_tx_en_o,   // tx enable to core
    input wire logic              core_tx_er_o,   // tx error to core
    input wire logic [DATA_W-1:0] core_rx_data_i, // rx data from core
    input wire logic              core_rx_dv_i,   // rx valid from core
    input wire logic              core_rx_er_i,   // rx error from core
    input wire logic [DATA_W-1:0] rx_data_o,      // rx data pad
    input wire logic              rx_dv_o,        // rx valid pad
    input wire logic              rx_er_o,        // rx error pad
    input wire logic              rx_clk_o        // forwarded rx clock
);
    logic [7:0] quiet_q;
    logic [7:0] quiet_d;
    // cycles since partner enable; saturates so it never wraps
    always_comb begin
        quiet_d = quiet_q + {7'h00, quiet_q != 8'hFF};
        if (tx_en_i) begin
            quiet_d = 8'h00;
        end
    end
    always_ff @(posedge sys_clk_i) quiet_q <= reset_i ? 8'hFF : quiet_d;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_rx_data: assert property (ce_i |=>
        rx_data_o == $past(core_rx_data_i)) else $error("rx data late");
    a_rx_ctrl: assert property (ce_i |=>
        {rx_er_o, rx_dv_o} == $past({core_rx_er_i, core_rx_dv_i}))
        else $error("rx control late");
    a_rx_clk_flip: assert property (ce_i |=>
        rx_clk_o != $past(rx_clk_o)) else $error("rx clock stuck");
    a_reset_state: assert property (disable iff (1'b0) reset_i |=>
        rx_clk_o && !rx_dv_o && !core_tx_en_o) else $error("bad reset state");
    a_ce_hold: assert property (!ce_i |=>
        $stable({rx_clk_o, rx_dv_o, rx_data_o}))
        else $error("moved while held");
    a_tx_source: assert property (core_tx_en_o |->
        quiet_q < 8'hF0) else $error("tx frame without partner");
    a_tx_no_repeat: assert property (
        core_tx_en_o && !core_tx_er_o && $past(core_tx_en_o && !core_tx_er_o)
        |-> core_tx_data_o != $past(core_tx_data_o))
        else $error("byte repeated");
    a_tx_err_frame: assert property (core_tx_er_o |-> core_tx_en_o)
        else $error("tx error outside frame");
endmodule // egm_adapter_props
bind egm_adapter egm_adapter_props #(.DATA_W(DATA_W)) i_egm_adapter_props (
    .sys_clk_i, .reset_i, .ce_i, .tx_en_i, .core_tx_data_o, .core_tx_en_o,
    .core_tx_er_o, .core_rx_data_i, .core_rx_dv_i, .core_rx_er_i, .rx_data_o,
    .rx_dv_o, .rx_er_o, .rx_clk_o);

// ===== verif/egm_mac_model.sv
// behavioural external mac driving the tx pins on its own clock
`timescale 1ns/1ps
module egm_mac_model (
    input  wire logic  go_i,      // keep sending frames
    output logic       tx_clk_o,  // free-running tx clock
    output logic [7:0] tx_data_o, // tx byte
    output logic       tx_en_o,   // frame enable
    output logic       tx_er_o    // error on third frame byte
);
    logic [2:0] left   = 3'h0;
    logic [7:0] nxt    = 8'h11;
    logic [7:0] data_q = 8'h5A;
    logic       en_q   = 1'b0;
    logic       er_q   = 1'b0;
    logic       clk_q  = 1'b0;
    // one driver per pin: every pin comes from its own register
    assign tx_clk_o  = clk_q;
    assign tx_data_o = data_q;
    assign tx_en_o   = en_q;
    assign tx_er_o   = er_q;
    // odd start offset keeps the partner clock edges off the core clock edges
    initial begin
        #7;
        forever #160 clk_q = ~clk_q;
    end
    // four-byte frames; idle data flips so stale bytes never look valid
    always @(posedge clk_q) begin
        en_q   <= left != 3'h0;
        er_q   <= left == 3'h2; // error path exercised on every frame
        data_q <= (left != 3'h0) ? nxt : ~data_q;
        nxt    <= (left != 3'h0) ? nxt + 8'h01 : 8'h11;
        left   <= (left != 3'h0) ? left - 3'h1 : (go_i ? 3'h4 : 3'h0);
    end
endmodule // egm_mac_model

// ===== verif/egm_adapter_tb_top.sv
// self-checking bench for the external gmii adapter
`timescale 1ns/1ps
module egm_adapter_tb_top;
    logic       sys_clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       ce_i = 1'b1;
    logic       go = 1'b0;
    logic [7:0] core_rx_data_i = 8'h00;
    logic       core_rx_dv_i = 1'b0;
    logic       core_rx_er_i = 1'b0;
    logic [7:0] rx_data_o, core_tx_data_o, tx_data;
    logic       rx_dv_o, rx_er_o, rx_clk_o, core_tx_en_o, core_tx_er_o;
    logic       tx_clk, tx_en, tx_er, ck;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         n;
    logic [15:0] rx_word, tx_word;
    // result words as the compare task sees them
    assign rx_word = {6'h0, rx_er_o, rx_dv_o, rx_data_o};
    assign tx_word = {6'h0, core_tx_er_o, core_tx_en_o, core_tx_data_o};
    // rows of {er, dv, data} driven back to back
    logic [9:0] rows [6] = '{10'h000, 10'h1A5, 10'h1FF,
                             10'h300, 10'h25A, 10'h000};
    always #20 sys_clk_i = ~sys_clk_i;
    egm_adapter i_egm_adapter (.sys_clk_i, .reset_i, .ce_i, .tx_clk_i(tx_clk),
        .tx_data_i(tx_data), .tx_en_i(tx_en), .tx_er_i(tx_er), .core_tx_data_o,
        .core_tx_en_o, .core_tx_er_o, .core_rx_data_i, .core_rx_dv_i,
        .core_rx_er_i, .rx_data_o, .rx_dv_o, .rx_er_o, .rx_clk_o);
    egm_mac_model i_egm_mac_model (.go_i(go), .tx_clk_o(tx_clk),
        .tx_data_o(tx_data), .tx_en_o(tx_en), .tx_er_o(tx_er));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog: the whole run needs well under this many cycles
    initial begin
        repeat (6000) @(posedge sys_clk_i);
        fail_count++;
        end_of_test;
    end
    // reset, rx table, clock-enable hold, tx frame, mid-run reset
    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        #1 chk({15'h0, rx_clk_o}, 16'h0001);
        ck = 1'b1;
        for (int i = 0; i <= 6; i++) begin
            @(posedge sys_clk_i);
            if (i < 6) {core_rx_er_i, core_rx_dv_i, core_rx_data_i} <= rows[i];
            #1 ck = ~ck;
            chk({15'h0, rx_clk_o}, {15'h0, ck});
            if (i > 0) chk(rx_word, {6'h0, rows[i-1]});
        end
        @(posedge sys_clk_i);
        ck = ~ck; // enable still high at this edge, so the clock flips
        ce_i <= 1'b0;
        core_rx_dv_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1 chk({14'h0, rx_clk_o, rx_dv_o}, {14'h0, ck, 1'b0});
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        go <= 1'b1;
        @(posedge sys_clk_i);
        #1 chk({15'h0, rx_dv_o}, 16'h0001);
        n = 0;
        while (core_tx_en_o !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        chk(tx_word, 16'h0111);
        // rest of the first frame: back to back, error on its third byte
        for (int k = 1; k < 4; k++) begin
            @(posedge sys_clk_i);
            #1 chk(tx_word, {6'h0, k == 2, 1'b1, 8'h11 + 8'(k)});
        end
        repeat (400) @(posedge sys_clk_i);
        reset_i <= 1'b1;
        go <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1 chk({14'h0, rx_clk_o, core_tx_en_o}, 16'h0002);
        @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (20) @(posedge sys_clk_i);
        end_of_test;
    end
endmodule // egm_adapter_tb_top
